// file: design/ebra_arbiter.sv
// Behaviour
// [R1] External request beats refresh, DMA, then CPU
// [R2] Master uses request input, watches acknowledge only
// [R3] Finish running cycle, then release and acknowledge
// [R4] Refresh while released raises the acknowledge
// [R5] Bus stays released while request stays low
// [R6] On request high: retake, refresh first, resume
// [R7] Master drops request soon after acknowledge rises
// [R8] Refresh at release: acknowledge high, still release
// [R9] Master times out missing acknowledge, drops request
// [R10] System avoids request and refresh collisions
// [R11] Master captures acknowledge in one flip-flop
// [R12] Sample request one state before cycle end; code samples half a state before
// [R13] Acknowledge one and a half states after end
// [R14] Late request waits through the following cycle
// [R15] Latency bounded by group plus 4.5 states
// [R16] Never release inside one logical bus cycle
// [R17] Test-and-set read and write stay together
// [R18] Refresh and following cycle stay together
// [R19] No internal cycles while bus is released
`timescale 1ns/1ps
`default_nettype none
`include "ebra_regs.svh"

module ebra_arbiter
    import ebra_pkg::*;
#(
    parameter int HALF_CLKS  = 1,
    parameter int LEN_W      = 4,
    parameter int REF_STATES = 2
) (
    // Clock and reset
    input  wire logic             I_CLK,
    input  wire logic             I_RST,
    // External master
    input  wire logic             I_BUS_REQUEST_N,
    output logic                  O_BUS_ACK_N,
    output logic                  O_BUS_OE_N,
    // Refresh timer
    input  wire logic             I_REFRESH_REQ,
    output logic                  O_REFRESH_GNT,
    // DMA controller
    input  wire logic             I_DMA_REQ,
    input  wire logic [LEN_W-1:0] I_DMA_LEN,
    input  wire logic             I_DMA_LOCK,
    output logic                  O_DMA_GNT,
    // CPU
    input  wire logic             I_CPU_REQ,
    input  wire logic [LEN_W-1:0] I_CPU_LEN,
    input  wire logic             I_CPU_LOCK,
    output logic                  O_CPU_GNT,
    // Cycle status
    output logic                  O_CYCLE_END
);

    // ****************************************************************
    // Half-state tick divider
    // ****************************************************************
    logic [7:0]  div_q;
    logic        tick;

    assign tick = (div_q == 8'(HALF_CLKS - 1));

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            div_q <= 8'h00;
        end else begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    ebra_state_e             state_q, state_d;
    ebra_tick_t              cnt_q, cnt_d;
    logic                    lock_q, lock_d;
    logic                    rel_pend_q, rel_pend_d;
    logic                    ref_pend_q;
    logic [`EBRA_SLOTS-1:0]  own_q, own_d;
    logic                    ack_n_q, ack_n_d;
    logic                    oe_n_q, oe_n_d;
    logic                    end_q;

    // ****************************************************************
    // Priority among internal requesters
    // ****************************************************************
    ebra_req_if #(.N(`EBRA_SLOTS)) rq ();

    ebra_prio #(.N(`EBRA_SLOTS)) u_prio (
        .rq (rq)
    );

    wire       in_cycle   = (state_q == EBRA_ST_CYCLE);
    wire       cycle_end  = tick && in_cycle && (cnt_q == ebra_tick_t'(1));
    wire       sample_pt  = tick && in_cycle && (cnt_q == ebra_tick_t'(`EBRA_SAMPLE_TICKS));
    // Inside a locked group a refresh may not slip in before the tail
    wire       ref_ok     = ref_pend_q && !(cycle_end && lock_q);
    assign rq.req = {I_CPU_REQ, I_DMA_REQ, ref_ok};
    wire       any_req    = |rq.req;
    wire [LEN_W-1:0] sel_len =
        rq.gnt[`EBRA_IDX_REF] ? LEN_W'(REF_STATES) :
        rq.gnt[`EBRA_IDX_DMA] ? I_DMA_LEN : I_CPU_LEN;
    wire [LEN_W-1:0] eff_len  = (sel_len == '0) ? LEN_W'(1) : sel_len;
    wire ebra_tick_t start_cnt = ebra_tick_t'(eff_len * `EBRA_HALF_PER_STATE);
    wire       sel_lock   = rq.gnt[`EBRA_IDX_REF] |                  // R18
                            (rq.gnt[`EBRA_IDX_DMA] & I_DMA_LOCK) |
                            (rq.gnt[`EBRA_IDX_CPU] & I_CPU_LOCK);   // R16 R17
    wire       ext_req    = !I_BUS_REQUEST_N;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        lock_d     = lock_q;
        rel_pend_d = rel_pend_q;
        own_d      = own_q;
        ack_n_d    = ack_n_q;
        oe_n_d     = oe_n_q;
        case (state_q)
            EBRA_ST_IDLE: begin
                if (tick && ext_req) begin
                    // Between cycles: the bus is free, release straight away
                    state_d = EBRA_ST_ACKWAIT;                       // R1
                    cnt_d   = ebra_tick_t'(`EBRA_ACK_TICKS);
                    oe_n_d  = 1'b1;
                end else if (tick && any_req) begin
                    state_d    = EBRA_ST_CYCLE;
                    cnt_d      = start_cnt;
                    lock_d     = sel_lock;
                    own_d      = rq.gnt;
                    rel_pend_d = 1'b0;
                    oe_n_d     = 1'b0;
                end
            end
            EBRA_ST_CYCLE: begin
                if (sample_pt) begin
                    rel_pend_d = ext_req;                            // R12 R14 R15
                end
                if (tick) begin
                    cnt_d = cnt_q - ebra_tick_t'(1);
                end
                if (cycle_end) begin
                    own_d = '0;
                    if (!lock_q && rel_pend_q) begin
                        state_d = EBRA_ST_ACKWAIT;                   // R1 R3
                        cnt_d   = ebra_tick_t'(`EBRA_ACK_TICKS);
                        oe_n_d  = 1'b1;
                    end else if (any_req) begin
                        // Locked group keeps the bus for its tail
                        state_d    = EBRA_ST_CYCLE;                  // R16 R17 R18
                        cnt_d      = start_cnt;
                        lock_d     = sel_lock;
                        own_d      = rq.gnt;
                        rel_pend_d = lock_q ? rel_pend_q : 1'b0;
                    end else begin
                        state_d = EBRA_ST_IDLE;
                    end
                end
            end
            EBRA_ST_ACKWAIT: begin
                if (tick) begin
                    cnt_d = cnt_q - ebra_tick_t'(1);
                    if (cnt_q == ebra_tick_t'(1)) begin
                        state_d    = EBRA_ST_RELEASED;               // R13
                        // Refresh colliding with release leaves ack high
                        ack_n_d    = ref_pend_q;                     // R8
                        rel_pend_d = 1'b0;
                    end
                end
            end
            EBRA_ST_RELEASED: begin
                ack_n_d = ref_pend_q;                                // R4 R5
                if (tick && !ext_req) begin
                    state_d = EBRA_ST_IDLE;                          // R6
                    ack_n_d = 1'b1;
                    oe_n_d  = 1'b0;
                end
            end
            default: begin
                state_d = EBRA_ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    wire ref_start = (state_d == EBRA_ST_CYCLE) && own_d[`EBRA_IDX_REF] &&
                     !own_q[`EBRA_IDX_REF];

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_q    <= EBRA_ST_IDLE;
            cnt_q      <= '0;
            lock_q     <= 1'b0;
            rel_pend_q <= 1'b0;
            own_q      <= '0;
            ack_n_q    <= 1'b1;
            oe_n_q     <= 1'b0;
            end_q      <= 1'b0;
            ref_pend_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            lock_q     <= lock_d;
            rel_pend_q <= rel_pend_d;
            own_q      <= own_d;
            ack_n_q    <= ack_n_d;
            oe_n_q     <= oe_n_d;
            end_q      <= cycle_end;
            // New request wins over the clear in the same cycle
            ref_pend_q <= I_REFRESH_REQ || (ref_pend_q && !ref_start);  // R6
        end
    end

    // Grants exist only in a cycle, never while released
    assign O_REFRESH_GNT = own_q[`EBRA_IDX_REF];                     // R19
    assign O_DMA_GNT     = own_q[`EBRA_IDX_DMA];
    assign O_CPU_GNT     = own_q[`EBRA_IDX_CPU];
    assign O_BUS_ACK_N   = ack_n_q;
    assign O_BUS_OE_N    = oe_n_q;
    assign O_CYCLE_END   = end_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    a_released_no_grant: assert property (  // R19
        (state_q == EBRA_ST_RELEASED) |-> (own_q == '0) && oe_n_q)
        else $error("grant or drive while bus released");

    a_refresh_raises_ack: assert property (  // R4
        (state_q == EBRA_ST_RELEASED) && ref_pend_q && ext_req |=> ack_n_q)
        else $error("ack not raised for pending refresh");

    a_released_holds: assert property (  // R5
        (state_q == EBRA_ST_RELEASED) && ext_req && tick
        |=> (state_q == EBRA_ST_RELEASED) && oe_n_q)
        else $error("bus retaken while request low");

    a_retake_refresh: assert property (  // R6
        (state_q == EBRA_ST_RELEASED) && !ext_req && tick && ref_pend_q
        && (HALF_CLKS == 1) |=> ##1 O_REFRESH_GNT)
        else $error("refresh not first after retake");

    a_idle_release: assert property (  // R1
        (state_q == EBRA_ST_IDLE) && tick && ext_req
        |=> (state_q == EBRA_ST_ACKWAIT) && oe_n_q && (own_q == '0))
        else $error("idle request not honoured first");

    a_group_kept: assert property (  // R16
        cycle_end && lock_q && (I_CPU_REQ || I_DMA_REQ)
        |=> (state_q == EBRA_ST_CYCLE) && ack_n_q)
        else $error("bus released inside locked group");

    a_ack_delay: assert property (  // R13
        cycle_end && !lock_q && rel_pend_q && (HALF_CLKS == 1)
        |=> (ack_n_q && oe_n_q) [*3] ##1 (state_q == EBRA_ST_RELEASED))
        else $error("release not 1.5 states after cycle end");

    a_sample_point: assert property (  // R12
        $rose(rel_pend_q) |-> $past(sample_pt) && $past(in_cycle))
        else $error("request sampled off the sample point");

    a_collide_release: assert property (  // R8
        (state_q == EBRA_ST_ACKWAIT) && tick && (cnt_q == ebra_tick_t'(1))
        && ref_pend_q |=> (state_q == EBRA_ST_RELEASED) && ack_n_q)
        else $error("release lost on refresh collision");

    c_release: cover property (
        (state_q == EBRA_ST_CYCLE) ##[1:40] !ack_n_q);
    c_refresh_in_release: cover property (
        !ack_n_q ##1 (state_q == EBRA_ST_RELEASED) && ack_n_q);
    c_locked_pair: cover property (
        cycle_end && lock_q ##1 in_cycle);

endmodule

`default_nettype wire

// file: design/ebra_prio.sv
`timescale 1ns/1ps
`default_nettype none

// Fixed priority pick: the lowest set request index wins, one-hot out
module ebra_prio #(
    parameter int N = 3
) (
    ebra_req_if.prio rq
);
    logic [N-1:0] below;

    generate
        for (genvar i = 0; i < N; i++) begin : g_pick
            if (i == 0) begin : g_first
                assign below[i] = 1'b0;
            end else begin : g_rest
                assign below[i] = below[i-1] | rq.req[i-1];
            end
            assign rq.gnt[i] = rq.req[i] & ~below[i];
        end
    endgenerate
endmodule

`default_nettype wire

// file: pkg/ebra_pkg.sv
package ebra_pkg;

    typedef enum logic [1:0] {
        EBRA_ST_IDLE,
        EBRA_ST_CYCLE,
        EBRA_ST_ACKWAIT,
        EBRA_ST_RELEASED
    } ebra_state_e;

    typedef logic [4:0] ebra_tick_t;

endpackage

// file: pkg/ebra_regs.svh
`ifndef EBRA_REGS_SVH
`define EBRA_REGS_SVH

// ****************************************************************
// Timing, in half bus states
// ****************************************************************
// One bus state is two half-state ticks
`define EBRA_HALF_PER_STATE    2
// Request sampled half a state before the end of a cycle (count 2, end at 1)
`define EBRA_SAMPLE_STATES     1
`define EBRA_SAMPLE_TICKS      (`EBRA_SAMPLE_STATES * `EBRA_HALF_PER_STATE)
// Acknowledge one and a half states after the last cycle ends
`define EBRA_ACK_HALF_STATES   3
`define EBRA_ACK_TICKS         `EBRA_ACK_HALF_STATES

// ****************************************************************
// Internal requester slots, lowest index wins
// ****************************************************************
`define EBRA_SLOTS             3
`define EBRA_IDX_REF           0
`define EBRA_IDX_DMA           1
`define EBRA_IDX_CPU           2

`endif

// file: pkg/ebra_req_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ebra_req_if #(
    parameter int N = 3
);
    logic [N-1:0] req;
    logic [N-1:0] gnt;

    modport arb  (output req, input  gnt);
    modport prio (input  req, output gnt);
endinterface

`default_nettype wire

// file: verification/ebra_arbiter_bench.sv
`timescale 1ns/1ps
`default_nettype none

module ebra_arbiter_bench;
    logic       clk;
    logic       rst;
    logic       want;
    logic       req_n;
    logic       ack_n;
    logic       oe_n;
    logic       ref_req;
    logic       ref_gnt;
    logic       dma_req;
    logic       dma_gnt;
    logic       dma_lock;
    logic       cpu_req;
    logic       cpu_lock;
    logic       cpu_gnt;
    logic       cyc_end;
    logic [3:0] cpu_len;
    int         err_count;
    int         total_checks;

    ebra_master_model #(.TMO(16)) master (.i_clk(clk), .i_rst(rst), .i_want(want),
        .i_ack_n(ack_n), .o_req_n(req_n));

    ebra_arbiter #(.HALF_CLKS(1), .LEN_W(4), .REF_STATES(2)) dut (.I_CLK(clk), .I_RST(rst),
        .I_BUS_REQUEST_N(req_n), .O_BUS_ACK_N(ack_n), .O_BUS_OE_N(oe_n),
        .I_REFRESH_REQ(ref_req), .O_REFRESH_GNT(ref_gnt), .I_DMA_REQ(dma_req),
        .I_DMA_LEN(4'h1), .I_DMA_LOCK(dma_lock), .O_DMA_GNT(dma_gnt), .I_CPU_REQ(cpu_req),
        .I_CPU_LEN(cpu_len), .I_CPU_LOCK(cpu_lock), .O_CPU_GNT(cpu_gnt),
        .O_CYCLE_END(cyc_end));

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Samples land 1 ns after the edge, clear of the flops' updates
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic next_gnt(input logic [2:0] prev, output logic [2:0] g);
        g = prev;
        for (int w = 0; w < 40 && (g === prev || g === 3'b000); w++) begin
            tick();
            g = {ref_gnt, dma_gnt, cpu_gnt};
        end
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_cpu(input logic [3:0] len);
        int n;
        @(posedge clk); cpu_len <= len; cpu_req <= 1'b1; #1;
        for (n = 0; n < 20 && cpu_gnt !== 1'b1; n++) tick();
        @(posedge clk); cpu_req <= 1'b0; #1;
        for (n = 1; n < 40 && cpu_gnt === 1'b1; n++) tick();
        check(8'(n), (len == 4'h0) ? 8'h02 : {3'h0, len, 1'b0});
        // The end pulse rises on the same edge that drops the grant
        check({7'h0, cyc_end}, 8'h01);
        tick();
        check({7'h0, cyc_end}, 8'h00);
    endtask

    task automatic t_prio;
        logic [2:0] g;
        // Refresh is latched first so all three requests stand at one grant edge
        @(posedge clk); ref_req <= 1'b1; cpu_len <= 4'h1; #1;
        @(posedge clk); ref_req <= 1'b0; dma_req <= 1'b1; cpu_req <= 1'b1; #1;
        next_gnt(3'b000, g);
        check({5'h0, g}, 8'h04);
        next_gnt(g, g);
        check({5'h0, g}, 8'h02);
        @(posedge clk); dma_req <= 1'b0; #1;
        next_gnt(g, g);
        check({5'h0, g}, 8'h01);
        @(posedge clk); cpu_req <= 1'b0; #1;
        tick(6);
    endtask

    task automatic t_release;
        logic [2:0] g;
        int         n;
        @(posedge clk); want <= 1'b1; #1;
        for (n = 0; n < 20 && oe_n !== 1'b1; n++) tick();
        for (n = 0; n < 20 && ack_n !== 1'b0; n++) tick();
        check(8'(n), 8'h03);
        @(posedge clk); cpu_req <= 1'b1; cpu_len <= 4'h1; #1;
        tick(8);
        check({5'h0, oe_n, ack_n, cpu_gnt}, 8'h04);
        @(posedge clk); ref_req <= 1'b1; #1;
        @(posedge clk); ref_req <= 1'b0; #1;
        for (n = 0; n < 10 && ack_n !== 1'b1; n++) tick();
        check({6'h0, ack_n, oe_n}, 8'h03);
        next_gnt(3'b000, g);
        check({4'h0, g, oe_n}, 8'h08);
        next_gnt(g, g);
        check({4'h0, g, oe_n}, 8'h02);
        @(posedge clk); cpu_req <= 1'b0; want <= 1'b0; #1;
        tick(6);
    endtask

    // Locked group from CPU or DMA defers the release past its tail cycle
    task automatic t_locked(input logic use_dma);
        int n;
        int w;
        @(posedge clk);
        if (use_dma) begin
            dma_req  <= 1'b1;
            dma_lock <= 1'b1;
        end else begin
            cpu_req  <= 1'b1;
            cpu_lock <= 1'b1;
            cpu_len  <= 4'h2;
        end
        #1;
        for (w = 0; w < 20 && (use_dma ? dma_gnt : cpu_gnt) !== 1'b1; w++) tick();
        @(posedge clk); want <= 1'b1; cpu_lock <= 1'b0; dma_lock <= 1'b0; #1;
        n = 0;
        for (w = 0; w < 40 && oe_n !== 1'b1; w++) begin
            tick();
            if (cyc_end === 1'b1) n++;
        end
        for (w = 0; w < 2; w++) begin
            tick();
            if (cyc_end === 1'b1) n++;
        end
        check(8'(n), 8'h02);
        for (w = 0; w < 20 && ack_n !== 1'b0; w++) tick();
        @(posedge clk); want <= 1'b0; #1;
        for (w = 0; w < 20 && (use_dma ? dma_gnt : cpu_gnt) !== 1'b1; w++) tick();
        check({5'h0, oe_n, ack_n, (use_dma ? dma_gnt : cpu_gnt)}, 8'h03);
        @(posedge clk); cpu_req <= 1'b0; dma_req <= 1'b0; #1;
        tick(8);
    endtask

    // Refresh lands on the release edge: no low acknowledge, master times out
    task automatic t_collide;
        logic [2:0] g;
        @(posedge clk); want <= 1'b1; ref_req <= 1'b1; #1;
        @(posedge clk); ref_req <= 1'b0; #1;
        // Well past the release point, before the master gives up
        tick(8);
        check({6'h0, oe_n, ack_n}, 8'h03);
        next_gnt(3'b000, g);
        check({4'h0, g, oe_n}, 8'h08);
        @(posedge clk); want <= 1'b0; #1;
        tick(6);
    endtask

    // ****************************************
    // Clock, reset, sequence and watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        rst = 1'b1; want = 1'b0; ref_req = 1'b0; dma_req = 1'b0;
        cpu_req = 1'b0; cpu_lock = 1'b0; cpu_len = 4'h1; dma_lock = 1'b0;
        err_count = 0; total_checks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check({5'h0, ack_n, oe_n, cyc_end}, 8'h04);
        check({5'h0, ref_gnt, dma_gnt, cpu_gnt}, 8'h00);
        tick();
        t_cpu(4'h0);
        t_cpu(4'h1);
        t_cpu(4'hF);
        $display("cycle length test done");
        t_prio();
        $display("priority test done");
        t_release();
        $display("release test done");
        t_locked(1'b0);
        t_locked(1'b1);
        $display("locked group test done");
        t_collide();
        $display("collision test done");
        tally_and_finish();
    end

    // Whole run needs well under a thousand clocks
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
endmodule

`default_nettype wire

// file: verification/ebra_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// External master: requests, watches acknowledge, gives up
// ****************************************
module ebra_master_model #(
    parameter int TMO = 16
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Bench control and device side
    input  wire logic i_want,
    input  wire logic i_ack_n,
    output logic      o_req_n
);
    logic       ack_q;
    logic       seen_q;
    logic       drop_q;
    logic [7:0] wait_q;

    // One capture flop only, so a narrow spike cannot split two readers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_q  <= 1'b1;
            seen_q <= 1'b0;
            drop_q <= 1'b0;
            wait_q <= 8'h00;
        end else begin
            ack_q <= i_ack_n;
            if (!i_want) begin
                seen_q <= 1'b0;
                drop_q <= 1'b0;
                wait_q <= 8'h00;
            end else begin
                if (!ack_q) seen_q <= 1'b1;
                if (seen_q && ack_q) drop_q <= 1'b1;
                if (!seen_q && !drop_q) wait_q <= wait_q + 8'h01;
                if (wait_q == 8'(TMO)) drop_q <= 1'b1;
            end
        end
    end

    assign o_req_n = !(i_want && !drop_q);
endmodule

`default_nettype wire
